// ---- hdl/discoverable_param_read.sv ----
// Serial responder that returns the constant discoverable parameter image.
`timescale 1ns/1ps
module discoverable_param_read (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic link_clock_i,
	input wire logic select_n_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	output logic serial_out_en_o,
	output logic read_active_o,
	output logic [7:0] read_addr_o
);
	// ============================================================
	// Link domain: shifting in on rising edges
	// Frame reset comes from select high so the link logic needs no edge
	// outside a frame; the link clock may stop between frames.
	logic frame_rst_n;
	param_read_pkg::phase_e phase_r;
	logic [2:0] bit_cnt_r;
	logic [1:0] addr_cnt_r;
	logic [6:0] shift_in_r;
	logic [7:0] addr_r;
	logic [7:0] rom_addr;
	logic [7:0] rom_data;
	logic [7:0] shift_out_r;
	logic out_drive_r;
	logic [7:0] byte_in;
	logic byte_done;
	logic cmd_ok;

	assign frame_rst_n = rst_n_i & ~select_n_i;
	assign byte_in = {shift_in_r, serial_in_i};
	assign byte_done = (bit_cnt_r == param_read_pkg::BIT_LAST);
	assign cmd_ok = (byte_in == param_read_pkg::CMD_READ_PARAMS);

	always_ff @(posedge link_clock_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_r <= 3'h0;
			shift_in_r <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_in_r <= byte_in[6:0];
		end
	end

	// Unknown commands park the frame in a silent state until select rises.
	logic bad_cmd_r;
	always_ff @(posedge link_clock_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_r <= param_read_pkg::PH_CMD;
			addr_cnt_r <= 2'h0;
			bad_cmd_r <= 1'b0;
		end else if (byte_done && !bad_cmd_r) begin
			case (phase_r)
				param_read_pkg::PH_CMD: begin
					if (cmd_ok) begin
						phase_r <= param_read_pkg::PH_ADDR;
					end else begin
						bad_cmd_r <= 1'b1;
					end
				end
				param_read_pkg::PH_ADDR: begin
					addr_cnt_r <= addr_cnt_r + 2'h1;
					if (addr_cnt_r == param_read_pkg::ADDR_BYTES_LAST) begin
						phase_r <= param_read_pkg::PH_DUMMY;
					end
				end
				param_read_pkg::PH_DUMMY: begin
					phase_r <= param_read_pkg::PH_DATA;
				end
				param_read_pkg::PH_DATA: begin
					phase_r <= param_read_pkg::PH_DATA;
				end
				default: begin
					phase_r <= param_read_pkg::PH_CMD;
				end
			endcase
		end
	end

	// Only the low address byte selects the image; higher bytes are ignored
	// and addresses past the image read as unused bytes.
	always_ff @(posedge link_clock_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			addr_r <= 8'h00;
		end else if (byte_done && phase_r == param_read_pkg::PH_ADDR) begin
			addr_r <= byte_in;
		end else if (byte_done && phase_r == param_read_pkg::PH_DATA) begin
			addr_r <= addr_r + 8'h01;
		end
	end

	// ============================================================
	// Link domain: shifting out on falling edges
	assign rom_addr = addr_r;

	param_image_rom u_rom (
		.addr_i(rom_addr),
		.data_o(rom_data)
	);

	// Falling-edge output gives the host a full half period of setup.
	always_ff @(negedge link_clock_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			shift_out_r <= 8'h00;
			out_drive_r <= 1'b0;
		end else if (phase_r == param_read_pkg::PH_DATA && !bad_cmd_r) begin
			out_drive_r <= 1'b1;
			if (bit_cnt_r == 3'h0) begin
				shift_out_r <= rom_data;
			end else begin
				shift_out_r <= {shift_out_r[6:0], 1'b0};
			end
		end
	end

	assign serial_out_o = shift_out_r[7];
	assign serial_out_en_o = out_drive_r;

	// ============================================================
	// System domain: status seen by local logic
	// Nothing here writes back into the device; the read is observe-only.
	logic active_sync;
	logic active_link;

	assign active_link = out_drive_r;

	sync_level u_sync_active (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.level_i(active_link),
		.level_o(active_sync)
	);

	param_read_pkg::read_status_s status_r;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_r <= '0;
		end else begin
			status_r.active <= active_sync;
			if (!active_sync) begin
				status_r.addr <= 8'h00;
			end else if (!status_r.active) begin
				status_r.addr <= 8'h01;
			end
		end
	end

	assign read_active_o = status_r.active;
	assign read_addr_o = status_r.addr;

endmodule

// ---- hdl/param_read_pkg.sv ----
// Package holding constants and types for the discoverable parameter responder.
package param_read_pkg;

	// ============================================================
	// Link command and framing
	localparam logic [7:0] CMD_READ_PARAMS = 8'h5a;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
	localparam int unsigned IMAGE_DEPTH = 128;
	localparam logic [7:0] IMAGE_LAST_ADDR = 8'h7f;
	localparam logic [7:0] UNUSED_BYTE = 8'hff;

	// ============================================================
	// Parameter image fields
	localparam logic [7:0] SIG_B0 = 8'h53;
	localparam logic [7:0] SIG_B1 = 8'h46;
	localparam logic [7:0] SIG_B2 = 8'h44;
	localparam logic [7:0] SIG_B3 = 8'h50;
	localparam logic [7:0] REV_MINOR = 8'h06;
	localparam logic [7:0] REV_MAJOR = 8'h01;
	localparam logic [7:0] HDR_COUNT = 8'h02;
	localparam logic [7:0] STD_ID = 8'h00;
	localparam logic [7:0] STD_LEN = 8'h10;
	localparam logic [7:0] STD_PTR = 8'h30;
	localparam logic [7:0] VND_REV_MINOR = 8'h00;
	localparam logic [7:0] VND_LEN = 8'h04;
	localparam logic [7:0] VND_PTR0 = 8'h10;
	localparam logic [7:0] VND_PTR1 = 8'h01;
	// Arbitrary neutral value that stands in for the maker's identity byte.
	localparam logic [7:0] VENDOR_ID = 8'h5e;
	localparam logic [7:0] ADDR4_ID = 8'h84;
	localparam logic [7:0] ADDR4_LEN = 8'h02;
	localparam logic [7:0] ADDR4_PTR = 8'hc0;
	localparam logic [7:0] PTR_HIGH = 8'h00;
	localparam logic [7:0] ERASE_CAPS = 8'he5;
	localparam logic [7:0] ERASE_4K_CMD = 8'h20;
	localparam logic [7:0] READ_CAPS = 8'hfb;
	localparam logic [7:0] DENSITY_LO = 8'hff;
	localparam logic [7:0] DENSITY_HI = 8'h7f;
	localparam logic [7:0] Q144_WAIT_MODE = 8'h44;
	localparam logic [7:0] Q144_CMD = 8'heb;
	localparam logic [7:0] Q114_WAIT_MODE = 8'h08;
	localparam logic [7:0] Q114_CMD = 8'h6b;
	localparam logic [7:0] D112_WAIT_MODE = 8'h08;
	localparam logic [7:0] D112_CMD = 8'h3b;
	localparam logic [7:0] D122_WAIT_MODE = 8'h04;
	localparam logic [7:0] D122_CMD = 8'hbb;
	localparam logic [7:0] WIDE_CAPS = 8'hfe;
	localparam logic [7:0] D222_WAIT_MODE = 8'h00;
	localparam logic [7:0] Q444_WAIT_MODE = 8'h44;
	localparam logic [7:0] Q444_CMD = 8'heb;
	localparam logic [7:0] ER1_SIZE = 8'h0c;
	localparam logic [7:0] ER2_SIZE = 8'h0f;
	localparam logic [7:0] ER2_CMD = 8'h52;
	localparam logic [7:0] ER3_SIZE = 8'h10;
	localparam logic [7:0] ER3_CMD = 8'hd8;
	localparam logic [7:0] ER4_SIZE = 8'h00;
	localparam logic [7:0] ERASE_TIME0 = 8'h87;
	localparam logic [7:0] ERASE_TIME1 = 8'h49;
	localparam logic [7:0] ERASE_TIME2 = 8'hbd;
	localparam logic [7:0] ERASE_TIME3 = 8'h00;
	localparam logic [7:0] PROG_MULT_PAGE = 8'h84;
	localparam logic [7:0] PROG_TIME = 8'hd2;
	localparam logic [7:0] BYTE_PROG_TIME = 8'h04;
	localparam logic [7:0] CHIP_ERASE_TIME = 8'he2;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_ADDR = 2'b01,
		PH_DUMMY = 2'b10,
		PH_DATA = 2'b11
	} phase_e;

	typedef struct packed {
		logic active;
		logic [7:0] addr;
	} read_status_s;

endpackage

// ---- hdl/sync_level.sv ----
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module sync_level (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic level_i,
	output logic level_o
);
	logic meta_r;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			level_o <= 1'b0;
		end else begin
			meta_r <= level_i;
			level_o <= meta_r;
		end
	end
endmodule

// ---- hdl/param_image_rom.sv ----
// Constant parameter image, combinational lookup by byte address.
`timescale 1ns/1ps
module param_image_rom (
	input wire logic [7:0] addr_i,
	output logic [7:0] data_o
);
	// ============================================================
	// Lookup
	always_comb begin
		case (addr_i)
			8'h00: data_o = param_read_pkg::SIG_B0;
			8'h01: data_o = param_read_pkg::SIG_B1;
			8'h02: data_o = param_read_pkg::SIG_B2;
			8'h03: data_o = param_read_pkg::SIG_B3;
			8'h04: data_o = param_read_pkg::REV_MINOR;
			8'h05: data_o = param_read_pkg::REV_MAJOR;
			8'h06: data_o = param_read_pkg::HDR_COUNT;
			8'h08: data_o = param_read_pkg::STD_ID;
			8'h09: data_o = param_read_pkg::REV_MINOR;
			8'h0a: data_o = param_read_pkg::REV_MAJOR;
			8'h0b: data_o = param_read_pkg::STD_LEN;
			8'h0c: data_o = param_read_pkg::STD_PTR;
			8'h0d: data_o = param_read_pkg::PTR_HIGH;
			8'h0e: data_o = param_read_pkg::PTR_HIGH;
			8'h10: data_o = param_read_pkg::VENDOR_ID;
			8'h11: data_o = param_read_pkg::VND_REV_MINOR;
			8'h12: data_o = param_read_pkg::REV_MAJOR;
			8'h13: data_o = param_read_pkg::VND_LEN;
			8'h14: data_o = param_read_pkg::VND_PTR0;
			8'h15: data_o = param_read_pkg::VND_PTR1;
			8'h16: data_o = param_read_pkg::PTR_HIGH;
			8'h18: data_o = param_read_pkg::ADDR4_ID;
			8'h19: data_o = param_read_pkg::VND_REV_MINOR;
			8'h1a: data_o = param_read_pkg::REV_MAJOR;
			8'h1b: data_o = param_read_pkg::ADDR4_LEN;
			8'h1c: data_o = param_read_pkg::ADDR4_PTR;
			8'h1d: data_o = param_read_pkg::PTR_HIGH;
			8'h1e: data_o = param_read_pkg::PTR_HIGH;
			8'h30: data_o = param_read_pkg::ERASE_CAPS;
			8'h31: data_o = param_read_pkg::ERASE_4K_CMD;
			8'h32: data_o = param_read_pkg::READ_CAPS;
			8'h34: data_o = param_read_pkg::DENSITY_LO;
			8'h35: data_o = param_read_pkg::DENSITY_LO;
			8'h36: data_o = param_read_pkg::DENSITY_LO;
			8'h37: data_o = param_read_pkg::DENSITY_HI;
			8'h38: data_o = param_read_pkg::Q144_WAIT_MODE;
			8'h39: data_o = param_read_pkg::Q144_CMD;
			8'h3a: data_o = param_read_pkg::Q114_WAIT_MODE;
			8'h3b: data_o = param_read_pkg::Q114_CMD;
			8'h3c: data_o = param_read_pkg::D112_WAIT_MODE;
			8'h3d: data_o = param_read_pkg::D112_CMD;
			8'h3e: data_o = param_read_pkg::D122_WAIT_MODE;
			8'h3f: data_o = param_read_pkg::D122_CMD;
			8'h40: data_o = param_read_pkg::WIDE_CAPS;
			8'h46: data_o = param_read_pkg::D222_WAIT_MODE;
			8'h4a: data_o = param_read_pkg::Q444_WAIT_MODE;
			8'h4b: data_o = param_read_pkg::Q444_CMD;
			8'h4c: data_o = param_read_pkg::ER1_SIZE;
			8'h4d: data_o = param_read_pkg::ERASE_4K_CMD;
			8'h4e: data_o = param_read_pkg::ER2_SIZE;
			8'h4f: data_o = param_read_pkg::ER2_CMD;
			8'h50: data_o = param_read_pkg::ER3_SIZE;
			8'h51: data_o = param_read_pkg::ER3_CMD;
			8'h52: data_o = param_read_pkg::ER4_SIZE;
			8'h54: data_o = param_read_pkg::ERASE_TIME0;
			8'h55: data_o = param_read_pkg::ERASE_TIME1;
			8'h56: data_o = param_read_pkg::ERASE_TIME2;
			8'h57: data_o = param_read_pkg::ERASE_TIME3;
			8'h58: data_o = param_read_pkg::PROG_MULT_PAGE;
			8'h59: data_o = param_read_pkg::PROG_TIME;
			8'h5a: data_o = param_read_pkg::BYTE_PROG_TIME;
			8'h5b: data_o = param_read_pkg::CHIP_ERASE_TIME;
			default: data_o = param_read_pkg::UNUSED_BYTE;
		endcase
	end
endmodule

// ---- dv/discoverable_param_read_monitor.sv ----
// Concurrent checks on the ports of the parameter responder.
`timescale 1ns/1ps
module discoverable_param_read_monitor (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic link_clock_i,
	input wire logic select_n_i,
	input wire logic serial_in_i,
	input wire logic serial_out_o,
	input wire logic serial_out_en_o,
	input wire logic read_active_o,
	input wire logic [7:0] read_addr_o
);
	// ========
	// Frame tracking in the link domain
	localparam logic [31:0] SIG_WORD = 32'h53464450;
	logic [7:0] cnt_r;
	logic [7:0] cmd_r;
	logic [7:0] addr_r;
	// The count saturates so a long stream never wraps back into the header window.
	always_ff @(posedge link_clock_i or posedge select_n_i) begin
		if (select_n_i) begin
			cnt_r <= 8'h00;
		end else if (cnt_r != 8'hff) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	always_ff @(posedge link_clock_i or posedge select_n_i) begin
		if (select_n_i) begin
			cmd_r <= 8'h00;
		end else if (cnt_r < 8'd8) begin
			cmd_r <= {cmd_r[6:0], serial_in_i};
		end
	end
	always_ff @(posedge link_clock_i or posedge select_n_i) begin
		if (select_n_i) begin
			addr_r <= 8'h00;
		end else if (cnt_r >= 8'd24 && cnt_r < 8'd32) begin
			addr_r <= {addr_r[6:0], serial_in_i};
		end
	end
	sequence header_done;
		cnt_r == 8'd40 && cmd_r == param_read_pkg::CMD_READ_PARAMS;
	endsequence
	sequence sig_window;
		cnt_r >= 8'd40 && cnt_r <= 8'd71 && addr_r == 8'h00 && cmd_r == 8'h5a;
	endsequence
	// ========
	// Link-side assertions
	chk_en_quiet_header: assert property (@(posedge link_clock_i)
		disable iff (select_n_i || !rst_n_i)
		cnt_r < 8'd40 |-> !serial_out_en_o)
		else $error("output enabled before the dummy byte ended");
	chk_en_after_dummy: assert property (@(posedge link_clock_i)
		disable iff (select_n_i || !rst_n_i)
		header_done |-> serial_out_en_o)
		else $error("no output after command, address and dummy");
	chk_refuse_cmd: assert property (@(posedge link_clock_i)
		disable iff (select_n_i || !rst_n_i)
		(cnt_r >= 8'd8 && cmd_r != 8'h5a) |-> !serial_out_en_o)
		else $error("output on a foreign command");
	chk_en_holds_byte: assert property (@(posedge link_clock_i)
		disable iff (select_n_i || !rst_n_i)
		$rose(serial_out_en_o) |-> serial_out_en_o[*8])
		else $error("output enable dropped inside a frame");
	chk_sig_stream: assert property (@(posedge link_clock_i)
		disable iff (select_n_i || !rst_n_i)
		sig_window |-> serial_out_o == SIG_WORD[5'(8'd71 - cnt_r)])
		else $error("signature bit wrong");
	// ========
	// System-side assertions
	chk_en_off_deselect: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		select_n_i |-> !serial_out_en_o)
		else $error("output driven while deselected");
	chk_out_stable_high: assert property (@(posedge clock_i)
		disable iff (!rst_n_i || select_n_i)
		(link_clock_i && $past(link_clock_i)) |-> $stable(serial_out_o))
		else $error("data moved on high clock");
	chk_active_rise: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		serial_out_en_o[*4] |-> read_active_o)
		else $error("activity marker late");
	chk_active_fall: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		select_n_i[*5] |-> !read_active_o && read_addr_o == 8'h00)
		else $error("marker stuck after select");
	chk_marker_addr: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		read_active_o |-> read_addr_o == 8'h01)
		else $error("marker address wrong while active");
endmodule
bind discoverable_param_read discoverable_param_read_monitor discoverable_param_read_monitor_inst (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .link_clock_i(link_clock_i), .select_n_i(select_n_i),
	.serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .serial_out_en_o(serial_out_en_o),
	.read_active_o(read_active_o), .read_addr_o(read_addr_o));

// ---- dv/param_host_model.sv ----
// Host serial master model that reads the parameter image in mode 0.
`timescale 1ns/1ps
module param_host_model (
	output logic link_clock_o,
	output logic select_n_o,
	output logic serial_in_o,
	input wire logic serial_out_i,
	input wire logic serial_out_en_i
);
	// ========
	// Frame driver
	logic [7:0] rx_q[$];
	logic en_seen;
	initial begin
		link_clock_o = 1'b0;
		select_n_o = 1'b1;
		serial_in_o = 1'b0;
	end
	// The clock stands low between frames; nbits may stop inside a byte to abort.
	task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int nbits);
		logic [39:0] hdr;
		logic [7:0] sh;
		hdr = {cmd, addr, 8'h00};
		rx_q.delete();
		en_seen = 1'b0;
		sh = 8'h00;
		select_n_o = 1'b0;
		#80;
		for (int i = 39; i >= 0; i--) begin
			serial_in_o = hdr[i];
			#80 link_clock_o = 1'b1;
			#80 link_clock_o = 1'b0;
		end
		for (int i = 0; i < nbits; i++) begin
			// Input means nothing now; toggling it keeps a stale level from passing for data.
			serial_in_o = ~serial_in_o;
			#80 link_clock_o = 1'b1;
			en_seen = en_seen | serial_out_en_i;
			// A released line shows the inverse so an idle output never passes for data.
			sh = {sh[6:0], serial_out_en_i ? serial_out_i : ~serial_out_i};
			if (i % 8 == 7) begin
				rx_q.push_back(sh);
			end
			#80 link_clock_o = 1'b0;
		end
		#80 select_n_o = 1'b1;
		#160;
	endtask
endmodule

// ---- dv/discoverable_param_read_tb_top.sv ----
// Testbench for the parameter responder.
`timescale 1ns/1ps
module discoverable_param_read_tb_top;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic link_clock, select_n, serial_in, serial_out, serial_out_en, read_active;
	logic [7:0] read_addr;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [7:0] hdr_exp[32] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hff,
		8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h01, 8'h04,
		8'h10, 8'h01, 8'h00, 8'hff, 8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00, 8'hff};
	logic [7:0] std_exp[42] = '{8'he5, 8'h20, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f,
		8'h44, 8'heb, 8'h08, 8'h6b, 8'h08, 8'h3b, 8'h04, 8'hbb, 8'hfe, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h44, 8'heb, 8'h0c, 8'h20, 8'h0f, 8'h52,
		8'h10, 8'hd8, 8'h00, 8'hff, 8'h87, 8'h49, 8'hbd, 8'h00, 8'h84, 8'hd2};
	always #10 clock_i = ~clock_i;
	discoverable_param_read discoverable_param_read_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.link_clock_i(link_clock), .select_n_i(select_n), .serial_in_i(serial_in),
		.serial_out_o(serial_out), .serial_out_en_o(serial_out_en), .read_active_o(read_active),
		.read_addr_o(read_addr));
	param_host_model param_host_model_inst (.link_clock_o(link_clock), .select_n_o(select_n),
		.serial_in_o(serial_in), .serial_out_i(serial_out), .serial_out_en_i(serial_out_en));
	// ========
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic read_image(input logic [7:0] cmd, input logic [23:0] addr, input int nbytes);
		param_host_model_inst.frame(cmd, addr, nbytes * 8);
		check(param_host_model_inst.rx_q.size(), nbytes);
	endtask
	function automatic logic [7:0] rx(input int i);
		return param_host_model_inst.rx_q[i];
	endfunction
	// ========
	// Scenarios
	initial begin
		repeat (4) @(negedge clock_i);
		rst_n_i = 1'b1;
		check(serial_out_en, 1'b0);
		#7;
		read_image(param_read_pkg::CMD_READ_PARAMS, 24'h000000, 32);
		check(param_host_model_inst.en_seen, 1'b1);
		for (int i = 0; i < 8; i++) begin
			check(rx(i), hdr_exp[i]);
		end
		for (int i = 8; i < 16; i++) begin
			check(rx(i), hdr_exp[i]);
		end
		check(rx(16), param_read_pkg::VENDOR_ID);
		for (int i = 17; i < 24; i++) begin
			check(rx(i), hdr_exp[i]);
		end
		for (int i = 24; i < 32; i++) begin
			check(rx(i), hdr_exp[i]);
		end
		read_image(param_read_pkg::CMD_READ_PARAMS, 24'h000030, 42);
		for (int i = 0; i < 8; i++) begin
			check(rx(i), std_exp[i]);
		end
		for (int i = 8; i < 16; i++) begin
			check(rx(i), std_exp[i]);
		end
		for (int i = 16; i < 28; i++) begin
			check(rx(i), std_exp[i]);
		end
		for (int i = 28; i < 36; i++) begin
			check(rx(i), std_exp[i]);
		end
		for (int i = 36; i < 42; i++) begin
			check(rx(i), std_exp[i]);
		end
		read_image(param_read_pkg::CMD_READ_PARAMS, 24'h0000fe, 3);
		check({rx(0), rx(1), rx(2)}, 24'hffff53);
		param_host_model_inst.frame(8'h03, 24'h000000, 16);
		check(param_host_model_inst.en_seen, 1'b0);
		param_host_model_inst.frame(param_read_pkg::CMD_READ_PARAMS, 24'h000004, 12);
		check(rx(0), 8'h06);
		check(serial_out_en, 1'b0);
		read_image(param_read_pkg::CMD_READ_PARAMS, 24'h000000, 1);
		check(rx(0), 8'h53);
		repeat (5) @(negedge clock_i);
		check({read_active, read_addr}, 9'h000);
		print_verdict();
	end
	initial begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
endmodule
